// [core/fcsl_code_store.sv]
// Six-entry append-only store of trouble codes with registered read.
`timescale 1ns/100ps
module fcsl_code_store
	import fcsl_pkg::*;
(
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             reset,
	// Append port
	input  wire logic             wr_en,
	input  wire fcsl_code_t       wr_code,
	// Read port
	input  wire logic [IDX_W-1:0] rd_addr,
	output fcsl_code_t            rd_code,
	// Fill level
	output logic [IDX_W-1:0]      count,
	output logic                  full
);
	fcsl_code_t mem [0:STORE_DEPTH-1];

	assign full = (count == IDX_W'(STORE_DEPTH)); // RULE9

	// Only power loss clears the store; there is no other clear.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			count   <= '0; // RULE12
			rd_code <= '0;
			for (int i = 0; i < STORE_DEPTH; i++) begin
				mem[i] <= '0;
			end
		end else begin
			if (wr_en && !full) begin
				mem[count] <= wr_code; // RULE11
				count      <= count + 1'b1;
			end
			rd_code <= mem[rd_addr];
		end
	end

	property p_store_cap;
		@(posedge clk) disable iff (reset) count <= IDX_W'(STORE_DEPTH);
	endproperty
	a_store_cap: assert property (p_store_cap) // RULE9
		else $error("code store holds more than six codes");

	property p_store_keeps;
		@(posedge clk) disable iff (reset) count >= $past(count);
	endproperty
	a_store_keeps: assert property (p_store_keeps) // RULE12
		else $error("stored codes were lost without reset");

	property p_store_order;
		@(posedge clk) disable iff (reset)
		wr_en && !full |=> mem[$past(count)] == $past(wr_code);
	endproperty
	a_store_order: assert property (p_store_order) // RULE11
		else $error("new code not appended after the older ones");
endmodule

// [core/fcsl_fault_lamp_ctrl.sv]
// Fault recording, key-on self-test, lamp flashing and cam-loss injection sequencing.
`timescale 1ns/100ps

// Contract
// RULE1: At key-on the lamp lights for a self-test of two to three seconds.
// RULE2: With any code stored, the lamp stays lit outside flash retrieval.
// RULE3: A detected malfunction stores its code and lights the lamp.
// RULE4: Holding the test button flashes the stored codes; release stops it.
// RULE5: Each flash is 0.4 s lit then 0.4 s dark.
// RULE6: The lamp stays dark 1.2 s between the two digits of a code.
// RULE7: The lamp stays dark 2.4 s between one code and the next.
// RULE8: Each stored code is flashed three times before the next one.
// RULE9: The store holds at most six codes.
// RULE10: After the last stored code the sequence restarts with the first.
// RULE11: Codes are kept and shown oldest first.
// RULE12: Only power loss clears stored codes.
// RULE13: A bad cam pattern while running sets code 53.
// RULE14: On cam loss, injection continues from the last pulse, also across restarts.
// RULE15: Throttle position low is code 12, high is code 22.
// RULE16: Manifold pressure low is code 14, high is code 24.
// RULE17: Fuel pump low is code 31, high is code 41.
// RULE18: Exhaust oxygen low is code 32, high is code 42.
// RULE19: Coolant temperature high is code 33, low is code 43.
// RULE20: Intake air temperature high is code 35, low is code 45.
// RULE21: Extra or missing crank pulses are code 52.
// RULE22: Controller faults are codes 54, 55 and 56.
// RULE23: Each digit is that many flashes, tens digit first.
module fcsl_fault_lamp_ctrl
	import fcsl_pkg::*;
#(
	parameter int SELFTEST_CYC  = SELFTEST_MS * CYC_PER_MS,
	parameter int FLASH_CYC     = FLASH_MS * CYC_PER_MS,
	parameter int DIGIT_GAP_CYC = DIGIT_GAP_MS * CYC_PER_MS,
	parameter int CODE_GAP_CYC  = CODE_GAP_MS * CYC_PER_MS
) (
	// Clock and power-loss reset
	input  wire logic        clk,
	input  wire logic        reset,
	// Operator
	input  wire logic        key_on,
	input  wire logic        test_button,
	// Fault detection
	input  wire fcsl_fault_t faults,
	input  wire logic        engine_running,
	// Injection sequencing
	input  wire logic        cam_position_sync,
	input  wire logic        cam_position_lost,
	input  wire logic        injection_pulse,
	// Outputs
	output logic             fault_lamp,
	output logic [CYL_W-1:0] inj_cylinder,
	output logic             calc_sequential_injection
);

	// ------------------------------------------------------------
	// Self-test at key-on
	// ------------------------------------------------------------
	logic key_prev;
	logic st_running;
	wire  key_rise = key_on && !key_prev;

	fcsl_interval_timer #(.W(TMR_W)) u_selftest_timer (
		.clk     (clk),
		.reset   (reset),
		.load    (key_rise), // RULE1
		.length  (TMR_W'(SELFTEST_CYC)),
		.running (st_running),
		.done    ()
	);

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			key_prev <= 1'b0;
		end else begin
			key_prev <= key_on;
		end
	end

	// ------------------------------------------------------------
	// Fault recording
	// ------------------------------------------------------------
	// Each fault is stored once; a repeat of a stored fault is dropped.
	// When several faults are pending, the lowest bit is stored first.
	logic [NUM_FAULTS-1:0]  pending;
	logic [NUM_FAULTS-1:0]  recorded;
	logic [NUM_FAULTS-1:0]  gated;
	logic [FAULT_IDX_W-1:0] pick_idx;
	logic                   pick_valid;
	logic [IDX_W-1:0]       code_count;
	logic                   store_full;
	logic [IDX_W-1:0]       next_idx;
	fcsl_code_t             rd_code;

	always_comb begin
		gated = faults;
		gated[CAM_BIT] = faults.cam_position_pattern_bad && engine_running; // RULE13
	end

	always_comb begin
		pick_valid = 1'b0;
		pick_idx   = '0;
		for (int i = NUM_FAULTS - 1; i >= 0; i--) begin
			if (pending[i]) begin
				pick_valid = 1'b1;
				pick_idx   = FAULT_IDX_W'(i);
			end
		end
	end

	wire                  wr_en         = pick_valid && !store_full; // RULE3
	wire [NUM_FAULTS-1:0] clear_vec     = {{(NUM_FAULTS-1){1'b0}}, wr_en} << pick_idx;
	wire [NUM_FAULTS-1:0] next_recorded = recorded | clear_vec;
	// A new event is ORed in after the clear, so it is never lost.
	wire [NUM_FAULTS-1:0] next_pending  = (pending & ~clear_vec) | (gated & ~next_recorded);

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pending  <= '0;
			recorded <= '0;
		end else begin
			pending  <= next_pending;
			recorded <= next_recorded;
		end
	end

	fcsl_code_store u_store (
		.clk     (clk),
		.reset   (reset),
		.wr_en   (wr_en),
		.wr_code (FAULT_CODE[pick_idx]), // RULE15
		.rd_addr (next_idx),
		.rd_code (rd_code),
		.count   (code_count),
		.full    (store_full)
	);

	// ------------------------------------------------------------
	// Flash retrieval
	// ------------------------------------------------------------
	fcsl_state_t      state;
	fcsl_state_t      next_state;
	logic [IDX_W-1:0] idx;
	logic [3:0]       flash_cnt;
	logic [3:0]       next_flash_cnt;
	logic             digit_sel;
	logic             next_digit_sel;
	logic [REP_W-1:0] rep;
	logic [REP_W-1:0] next_rep;
	logic             seq_load;
	logic [TMR_W-1:0] seq_len;
	logic             seq_done;

	// Retrieval waits for the self-test so the operator never sees them mixed.
	wire       start      = test_button && key_on && !st_running && (code_count != '0);
	wire [3:0] cur_digit  = digit_sel ? rd_code.units : rd_code.tens; // RULE23
	wire       last_flash = ((flash_cnt + 4'h1) == cur_digit);
	wire       last_code  = (idx == (code_count - 1'b1));
	wire       last_rep   = (rep == REP_W'(CODE_REPEATS - 1));

	fcsl_interval_timer #(.W(TMR_W)) u_seq_timer (
		.clk     (clk),
		.reset   (reset),
		.load    (seq_load),
		.length  (seq_len),
		.running (),
		.done    (seq_done)
	);

	always_comb begin
		next_state     = state;
		next_idx       = idx;
		next_flash_cnt = flash_cnt;
		next_digit_sel = digit_sel;
		next_rep       = rep;
		seq_load       = 1'b0;
		seq_len        = TMR_W'(FLASH_CYC);
		if (!test_button) begin
			next_state = S_IDLE; // RULE4
		end else begin
			case (state)
				S_IDLE: begin
					if (start) begin
						next_state     = S_ON; // RULE4
						next_idx       = '0; // RULE11
						next_flash_cnt = '0;
						next_digit_sel = 1'b0;
						next_rep       = '0;
						seq_load       = 1'b1;
					end
				end
				S_ON: begin
					if (seq_done) begin
						seq_load       = 1'b1;
						next_flash_cnt = flash_cnt + 4'h1;
						if (!last_flash) begin
							next_state = S_OFF; // RULE5
						end else if (!digit_sel) begin
							next_state = S_DIGIT_GAP; // RULE6
							seq_len    = TMR_W'(DIGIT_GAP_CYC);
						end else begin
							next_state = S_CODE_GAP; // RULE7
							seq_len    = TMR_W'(CODE_GAP_CYC);
						end
					end
				end
				S_OFF: begin
					if (seq_done) begin
						next_state = S_ON;
						seq_load   = 1'b1;
					end
				end
				S_DIGIT_GAP: begin
					if (seq_done) begin
						next_state     = S_ON;
						next_digit_sel = 1'b1; // RULE23
						next_flash_cnt = '0;
						seq_load       = 1'b1;
					end
				end
				S_CODE_GAP: begin
					if (seq_done) begin
						next_state     = S_ON;
						next_digit_sel = 1'b0;
						next_flash_cnt = '0;
						seq_load       = 1'b1;
						if (last_rep) begin
							next_rep = '0; // RULE8
							next_idx = last_code ? '0 : idx + 1'b1; // RULE10
						end else begin
							next_rep = rep + 1'b1;
						end
					end
				end
				default: begin
					next_state = S_IDLE;
				end
			endcase
		end
	end

	wire next_lamp = (state != S_IDLE) ? (state == S_ON) : (st_running || (code_count != '0));

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state      <= S_IDLE;
			idx        <= '0;
			flash_cnt  <= '0;
			digit_sel  <= 1'b0;
			rep        <= '0;
			fault_lamp <= 1'b0;
		end else begin
			state      <= next_state;
			idx        <= next_idx;
			flash_cnt  <= next_flash_cnt;
			digit_sel  <= next_digit_sel;
			rep        <= next_rep;
			fault_lamp <= next_lamp; // RULE2
		end
	end

	// ------------------------------------------------------------
	// Injection sequencing
	// ------------------------------------------------------------
	// The position survives engine stops, so a restart while the cam
	// signal is still missing resumes the established order.
	wire             sync_ok  = cam_position_sync && !cam_position_lost;
	wire [CYL_W-1:0] cyl_inc  = (inj_cylinder == CYL_W'(NUM_CYL - 1)) ? '0 : inj_cylinder + 1'b1;
	wire [CYL_W-1:0] cyl_sync = injection_pulse ? CYL_W'(1) : '0;
	wire [CYL_W-1:0] next_cyl = sync_ok ? cyl_sync : (injection_pulse ? cyl_inc : inj_cylinder);

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			inj_cylinder              <= '0;
			calc_sequential_injection <= 1'b0;
		end else begin
			inj_cylinder              <= next_cyl; // RULE14
			calc_sequential_injection <= cam_position_lost;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	logic [TMR_W-1:0] phase_cnt;
	logic [TMR_W-1:0] st_cnt;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			phase_cnt <= '0;
			st_cnt    <= '0;
		end else begin
			phase_cnt <= (next_state != state) ? '0 : phase_cnt + 1'b1;
			st_cnt    <= key_rise ? '0 : (st_running ? st_cnt + 1'b1 : st_cnt);
		end
	end

	sequence s_lamp_lit;
		fault_lamp || (state != S_IDLE);
	endsequence

	property p_selftest_start;
		@(posedge clk) disable iff (reset) key_rise |=> st_running ##1 s_lamp_lit;
	endproperty
	a_selftest_start: assert property (p_selftest_start) // RULE1
		else $error("lamp not lit at key-on");

	property p_selftest_len;
		@(posedge clk) disable iff (reset) $fell(st_running) |-> st_cnt == TMR_W'(SELFTEST_CYC);
	endproperty
	a_selftest_len: assert property (p_selftest_len) // RULE1
		else $error("self-test interval has the wrong length");

	property p_steady_lamp;
		@(posedge clk) disable iff (reset) (state == S_IDLE) && (code_count != '0) |=> fault_lamp;
	endproperty
	a_steady_lamp: assert property (p_steady_lamp) // RULE2
		else $error("lamp not steady with codes stored");

	property p_record;
		@(posedge clk) disable iff (reset)
		wr_en |=> (code_count == $past(code_count) + 1'b1) ##1 s_lamp_lit;
	endproperty
	a_record: assert property (p_record) // RULE3
		else $error("malfunction not stored or lamp not lit");

	property p_release;
		@(posedge clk) disable iff (reset) !test_button |=> state == S_IDLE;
	endproperty
	a_release: assert property (p_release) // RULE4
		else $error("flashing continued after button release");

	property p_on_len;
		@(posedge clk) disable iff (reset)
		(state == S_ON) && (next_state != S_ON) && test_button |-> phase_cnt == TMR_W'(FLASH_CYC - 1);
	endproperty
	a_on_len: assert property (p_on_len) // RULE5
		else $error("lit part of a flash has the wrong length");

	property p_off_len;
		@(posedge clk) disable iff (reset)
		(state == S_OFF) && (next_state != S_OFF) && test_button |-> phase_cnt == TMR_W'(FLASH_CYC - 1);
	endproperty
	a_off_len: assert property (p_off_len) // RULE5
		else $error("dark part of a flash has the wrong length");

	property p_digit_gap;
		@(posedge clk) disable iff (reset)
		(state == S_DIGIT_GAP) && (next_state == S_ON) |-> phase_cnt == TMR_W'(DIGIT_GAP_CYC - 1);
	endproperty
	a_digit_gap: assert property (p_digit_gap) // RULE6
		else $error("gap between digits has the wrong length");

	property p_code_gap;
		@(posedge clk) disable iff (reset)
		(state == S_CODE_GAP) && (next_state == S_ON) |-> phase_cnt == TMR_W'(CODE_GAP_CYC - 1);
	endproperty
	a_code_gap: assert property (p_code_gap) // RULE7
		else $error("gap between codes has the wrong length");

	property p_repeat;
		@(posedge clk) disable iff (reset)
		(state == S_CODE_GAP) && (next_state == S_ON) && (code_count > IDX_W'(1))
		|=> (idx != $past(idx)) == ($past(rep) == REP_W'(CODE_REPEATS - 1));
	endproperty
	a_repeat: assert property (p_repeat) // RULE8
		else $error("code not repeated exactly three times");

	property p_wrap;
		@(posedge clk) disable iff (reset)
		(state == S_CODE_GAP) && (next_state == S_ON) && last_rep && last_code |=> idx == '0;
	endproperty
	a_wrap: assert property (p_wrap) // RULE10
		else $error("sequence did not restart at the first code");

	property p_tens_count;
		@(posedge clk) disable iff (reset)
		(state == S_ON) && (next_state == S_DIGIT_GAP) |-> !digit_sel && (next_flash_cnt == rd_code.tens);
	endproperty
	a_tens_count: assert property (p_tens_count) // RULE23
		else $error("tens digit flashed the wrong number of times");

	property p_cam_code;
		@(posedge clk) disable iff (reset)
		faults.cam_position_pattern_bad && engine_running |=> pending[CAM_BIT] || recorded[CAM_BIT];
	endproperty
	a_cam_code: assert property (p_cam_code) // RULE13
		else $error("bad cam pattern while running not recorded");

	property p_calc_seq;
		@(posedge clk) disable iff (reset)
		cam_position_lost && injection_pulse |=> inj_cylinder == $past(cyl_inc) && calc_sequential_injection;
	endproperty
	a_calc_seq: assert property (p_calc_seq) // RULE14
		else $error("injection order not continued from last pulse");
endmodule

// [core/fcsl_interval_timer.sv]
// One-shot down counter that marks the last cycle of a loaded interval.
`timescale 1ns/100ps
module fcsl_interval_timer #(
	parameter int W = 27
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         reset,
	// Control
	input  wire logic         load,
	input  wire logic [W-1:0] length,
	// Status
	output logic              running,
	output logic              done
);
	logic [W-1:0] count;

	assign done = running && (count == '0);

	// A load wins over the end of the running interval, so a chain of
	// intervals has no idle cycle between them.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			count   <= '0;
			running <= 1'b0;
		end else if (load) begin
			count   <= length - 1'b1;
			running <= 1'b1;
		end else if (done) begin
			running <= 1'b0;
		end else if (running) begin
			count <= count - 1'b1;
		end
	end
endmodule

// [core/fcsl_pkg.sv]
// Shared constants, code table and types of the fault code store and lamp flasher.
package fcsl_pkg;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_HZ       = 40_000_000;
	localparam int MS_PER_S     = 1000;
	localparam int CYC_PER_MS   = CLK_HZ / MS_PER_S;
	localparam int SELFTEST_MS  = 2500;
	localparam int FLASH_MS     = 400;
	localparam int DIGIT_GAP_MS = 1200;
	localparam int CODE_GAP_MS  = 2400;
	localparam int TMR_W        = 27;

	// ------------------------------------------------------------
	// Sizes
	// ------------------------------------------------------------
	localparam int STORE_DEPTH  = 6;
	localparam int IDX_W        = 3;
	localparam int CODE_REPEATS = 3;
	localparam int REP_W        = 2;
	localparam int NUM_CYL      = 4;
	localparam int CYL_W        = 2;
	localparam int NUM_FAULTS   = 17;
	localparam int FAULT_IDX_W  = 5;
	localparam int CAM_BIT      = 3;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	// A code is held as two decimal digits, tens then units.
	typedef struct packed {
		logic [3:0] tens;
		logic [3:0] units;
	} fcsl_code_t;

	// Fault event pulses; the last member is bit 0.
	typedef struct packed {
		logic throttle_position_low;
		logic throttle_position_high;
		logic manifold_pressure_low;
		logic manifold_pressure_high;
		logic fuel_pump_low;
		logic fuel_pump_high;
		logic exhaust_oxygen_sensor_low;
		logic exhaust_oxygen_sensor_high;
		logic coolant_temperature_high;
		logic coolant_temperature_low;
		logic intake_air_temperature_high;
		logic intake_air_temperature_low;
		logic crank_position_pulse_error;
		logic cam_position_pattern_bad;
		logic controller_illegal_operation;
		logic controller_illegal_interrupt;
		logic operating_watchdog_fail;
	} fcsl_fault_t;

	typedef enum logic [2:0] {
		S_IDLE      = 3'h0,
		S_ON        = 3'h1,
		S_OFF       = 3'h2,
		S_DIGIT_GAP = 3'h3,
		S_CODE_GAP  = 3'h4
	} fcsl_state_t;

	// Code for each fault bit, indexed by bit position.
	localparam fcsl_code_t FAULT_CODE [0:NUM_FAULTS-1] = '{
		8'h56, // RULE22
		8'h55, // RULE22
		8'h54, // RULE22
		8'h53, // RULE13
		8'h52, // RULE21
		8'h45, // RULE20
		8'h35, // RULE20
		8'h43, // RULE19
		8'h33, // RULE19
		8'h42, // RULE18
		8'h32, // RULE18
		8'h41, // RULE17
		8'h31, // RULE17
		8'h24, // RULE16
		8'h14, // RULE16
		8'h22, // RULE15
		8'h12  // RULE15
	};

endpackage

// [verification/fcsl_fault_lamp_ctrl_tb.sv]
// Self-checking testbench of the fault code store and lamp flasher.
`timescale 1ns/100ps
module fcsl_fault_lamp_ctrl_tb
	import fcsl_pkg::*;
;
	// ------------------------------------------------------------
	// Settings and signals
	// ------------------------------------------------------------
	localparam int SELFTEST  = 40;
	localparam int FLASH     = 8;
	localparam int DIGIT_GAP = 24;
	localparam int CODE_GAP  = 48;
	localparam logic [7:0] EXP_CODE [0:16] = '{8'h56, 8'h55, 8'h54, 8'h53, 8'h52, 8'h45,
		8'h35, 8'h43, 8'h33, 8'h42, 8'h32, 8'h41, 8'h31, 8'h24, 8'h14, 8'h22, 8'h12};
	localparam int ORDER [0:6] = '{5, 16, 3, 9, 0, 12, 10};

	logic             clk;
	logic             reset;
	logic             key_on;
	logic             test_button;
	fcsl_fault_t      faults;
	logic             engine_running;
	logic             cam_position_sync;
	logic             cam_position_lost;
	logic             injection_pulse;
	logic             fault_lamp;
	logic [CYL_W-1:0] inj_cylinder;
	logic             calc_sequential_injection;
	int               fail_count = 0;
	int               tests_run = 0;

	// Reset itself is raised by the first scenario at time zero.
	initial begin
		clk = 1'b0;
		faults = '0;
		engine_running = 1'b0;
		cam_position_sync = 1'b0;
		cam_position_lost = 1'b0;
		injection_pulse = 1'b0;
	end

	always #12.5 clk = ~clk;

	fcsl_fault_lamp_ctrl #(
		.SELFTEST_CYC (SELFTEST),
		.FLASH_CYC    (FLASH),
		.DIGIT_GAP_CYC(DIGIT_GAP),
		.CODE_GAP_CYC (CODE_GAP)
	) dut (
		.clk                      (clk),
		.reset                    (reset),
		.key_on                   (key_on),
		.test_button              (test_button),
		.faults                   (faults),
		.engine_running           (engine_running),
		.cam_position_sync        (cam_position_sync),
		.cam_position_lost        (cam_position_lost),
		.injection_pulse          (injection_pulse),
		.fault_lamp               (fault_lamp),
		.inj_cylinder             (inj_cylinder),
		.calc_sequential_injection(calc_sequential_injection)
	);

	fcsl_operator #(.FLASH_CYC(FLASH)) op (
		.clk        (clk),
		.fault_lamp (fault_lamp),
		.key_on     (key_on),
		.test_button(test_button)
	);

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %0h, seen %0h", what, exp, seen);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic apply_reset();
		reset = 1'b1;
		tick(10);
		reset = 1'b0;
	endtask

	task automatic fire(input int i);
		faults = fcsl_fault_t'(17'h1 << i);
		tick(1);
		faults = '0;
		// A quiet cycle keeps back-to-back calls from driving faults twice in one step.
		tick(1);
	endtask

	task automatic pulse(input logic sync, input logic inj);
		cam_position_sync = sync;
		injection_pulse = inj;
		tick(1);
		cam_position_sync = 1'b0;
		injection_pulse = 1'b0;
		tick(1);
	endtask

	task automatic read_expect(input logic [7:0] code, input bit fresh);
		int tens, units, g1, g2, bad;
		op.read_code(fresh, tens, units, g1, g2, bad);
		check("tens digit", tens, code[7:4]);
		check("units digit", units, code[3:0]);
		check("flash length", bad, 0);
		check("digit gap", g1, DIGIT_GAP);
		check("code gap", g2, CODE_GAP);
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_selftest();
		int n, k;
		apply_reset();
		tick(5);
		check("lamp after reset", fault_lamp, 1'b0);
		op.turn_key(1'b1);
		n = 0;
		k = 0;
		while (fault_lamp !== 1'b1 && k < 10) begin
			tick(1);
			k++;
		end
		while (fault_lamp === 1'b1 && n < 400) begin
			tick(1);
			n++;
		end
		check("self-test length", n, SELFTEST);
		fire(CAM_BIT);
		tick(4);
		check("cam fault with engine stopped", fault_lamp, 1'b0);
		$display("test done: self-test");
	endtask

	task automatic t_code_table();
		engine_running = 1'b1;
		for (int i = 0; i < NUM_FAULTS; i++) begin
			apply_reset();
			tick(SELFTEST + 10);
			check("lamp with no code", fault_lamp, 1'b0);
			fire(i);
			tick(4);
			check("lamp on fault", fault_lamp, 1'b1);
			op.press(1'b1);
			read_expect(EXP_CODE[i], 1'b1);
			op.press(1'b0);
		end
		$display("test done: code table");
	endtask

	task automatic t_order_wrap();
		int z;
		apply_reset();
		tick(SELFTEST + 10);
		for (int i = 0; i < 7; i++)
			fire(ORDER[i]);
		tick(10);
		op.press(1'b1);
		for (int r = 0; r < 19; r++)
			read_expect(EXP_CODE[ORDER[(r / 3) % 6]], r == 0);
		op.press(1'b0);
		tick(3);
		z = 0;
		for (int c = 0; c < 60; c++) begin
			if (fault_lamp !== 1'b1)
				z++;
			tick(1);
		end
		check("steady lamp after release", z, 0);
		op.turn_key(1'b0);
		op.turn_key(1'b1);
		tick(SELFTEST + 10);
		op.press(1'b1);
		read_expect(EXP_CODE[ORDER[0]], 1'b1);
		op.press(1'b0);
		$display("test done: order and wrap");
	endtask

	task automatic t_injection();
		pulse(1'b0, 1'b1);
		pulse(1'b0, 1'b1);
		check("cylinder after two pulses", inj_cylinder, 2'h2);
		pulse(1'b1, 1'b0);
		check("cylinder after sync", inj_cylinder, 2'h0);
		cam_position_lost = 1'b1;
		tick(2);
		check("calculated mode", calc_sequential_injection, 1'b1);
		pulse(1'b0, 1'b1);
		pulse(1'b1, 1'b0);
		check("sync ignored on cam loss", inj_cylinder, 2'h1);
		for (int i = 0; i < 3; i++)
			pulse(1'b0, 1'b1);
		check("cylinder wraps", inj_cylinder, 2'h0);
		engine_running = 1'b0;
		tick(5);
		engine_running = 1'b1;
		pulse(1'b0, 1'b1);
		check("sequence kept over restart", inj_cylinder, 2'h1);
		cam_position_lost = 1'b0;
		tick(2);
		check("true sequential mode", calc_sequential_injection, 1'b0);
		$display("test done: injection");
	endtask

	// ------------------------------------------------------------
	// Run control
	// ------------------------------------------------------------
	task automatic close_out();
		$display("comparisons %0d, mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// The whole run needs some 8000 cycles; the limit leaves ample margin.
	initial begin
		#2_000_000;
		fail_count++;
		close_out();
	end

	initial begin
		t_selftest();
		t_code_table();
		t_order_wrap();
		t_injection();
		close_out();
	end
endmodule

// [verification/fcsl_operator.sv]
// Operator model: turns the key, holds the test button and reads the lamp flashes.
`timescale 1ns/100ps
module fcsl_operator #(
	parameter int FLASH_CYC = 8
) (
	// Clock
	input  wire logic clk,
	// Lamp watched
	input  wire logic fault_lamp,
	// Controls worked
	output logic      key_on,
	output logic      test_button
);
	initial begin
		key_on = 1'b0;
		test_button = 1'b0;
	end

	// ------------------------------------------------------------
	// Controls
	// ------------------------------------------------------------
	task automatic turn_key(input logic v);
		@(posedge clk);
		#1;
		key_on = v;
	endtask

	// The button stays held for as long as the reading goes on.
	task automatic press(input logic v);
		@(posedge clk);
		#1;
		test_button = v;
	endtask

	// ------------------------------------------------------------
	// Lamp reading
	// ------------------------------------------------------------
	// A fresh digit starts on a lamp that was already steady, so its first lit run is longer.
	task automatic read_digit(input bit fresh, output int n, output int gap, output int bad);
		int run;
		n = 0;
		bad = 0;
		do begin
			run = 0;
			while (fault_lamp === 1'b1 && run < 400) begin
				@(posedge clk);
				#1;
				run++;
			end
			if (run != FLASH_CYC && !(fresh && n == 0))
				bad++;
			n++;
			gap = 0;
			while (fault_lamp !== 1'b1 && gap < 400) begin
				@(posedge clk);
				#1;
				gap++;
			end
		end while (gap == FLASH_CYC && n < 12);
	endtask

	task automatic read_code(input bit fresh, output int tens, output int units,
		output int gap1, output int gap2, output int bad);
		int b2;
		read_digit(fresh, tens, gap1, bad);
		read_digit(1'b0, units, gap2, b2);
		bad += b2;
	endtask
endmodule
